// ---- npe_cfg.svh ----
// constants of the nonvolatile page erase / byte write block
`ifndef NPE_CFG_SVH
`define NPE_CFG_SVH
`define NPE_ADDR_LOW   8'hC6
`define NPE_ADDR_KEY   8'hC7
`define NPE_ADDR_CTRL  8'hCE
`define NPE_ADDR_DATA  8'hCF
`define NPE_KEY_FIRST  8'hAA
`define NPE_KEY_SECOND 8'h55
`define NPE_WIN_MC     2'h3
`define NPE_BIT_ERASE  7
`define NPE_BIT_WRITE  6
`define NPE_PAGE_MSB   7
`define NPE_PAGE_LSB   6
`define NPE_PAGES      4
`define NPE_PAGE_BYTES 64
`define NPE_MEM_BYTES  256
`define NPE_ERASED     8'hFF
`define NPE_ZERO8      8'h00
`define NPE_CNT_W      16
`define NPE_ERASE_MC   16'h0040
`define NPE_WRITE_MC   16'h0010
`endif

// ---- npe_pkg.sv ----
// types of the nonvolatile page erase / byte write block
`include "npe_cfg.svh"
package npe_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } npe_sfr_req_t;

  typedef enum logic [1:0] {
    NPE_IDLE  = 2'b00,
    NPE_ERASE = 2'b01,
    NPE_WRITE = 2'b10
  } npe_op_t;

  typedef enum logic {
    NPE_K_IDLE  = 1'b0,
    NPE_K_ARMED = 1'b1
  } npe_key_st_t;

  typedef struct packed {
    npe_key_st_t key_st;
    logic [1:0]  win_cnt;
  } npe_unlock_t;

  typedef struct packed {
    npe_op_t                              op;
    logic [`NPE_CNT_W-1:0]                cnt;
    logic [7:0]                           addr_low;
    logic [7:0]                           wdata;
    logic [7:0]                           rdata;
    logic [7:0]                           movc_data;
    logic                                 done;
    logic [`NPE_MEM_BYTES-1:0][7:0]       mem;
  } npe_state_t;
endpackage

// ---- npe_unlock.sv ----
// timed-access unlock sequence and protected-bit write window
`timescale 1ns/1ps
`include "npe_cfg.svh"
module npe_unlock (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire npe_pkg::npe_sfr_req_t req,
  input  wire logic                  mc_tick,
  output logic                       win_open
);
  import npe_pkg::*;

  npe_unlock_t st_q;
  npe_unlock_t st_d;
  logic        key_wr;

  assign key_wr   = req.wr && (req.addr == `NPE_ADDR_KEY);
  assign win_open = (st_q.win_cnt != 2'h0);

  always_comb begin
    st_d = st_q;
    if (mc_tick && st_q.win_cnt != 2'h0) begin
      st_d.win_cnt = st_q.win_cnt - 2'h1;
    end
    if (req.wr) begin
      if (key_wr && req.wdata == `NPE_KEY_FIRST) begin
        st_d.key_st = NPE_K_ARMED;
      end else if (key_wr && req.wdata == `NPE_KEY_SECOND && st_q.key_st == NPE_K_ARMED) begin
        st_d.key_st  = NPE_K_IDLE;
        st_d.win_cnt = `NPE_WIN_MC;
      end else begin
        // any other write in between breaks the sequence
        st_d.key_st = NPE_K_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '{key_st: NPE_K_IDLE, win_cnt: 2'h0};
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  AST_WIN_OPENS_ON_KEY: assert property (@(posedge clk) disable iff (srst)
    $rose(win_open) |-> $past(key_wr && req.wdata == `NPE_KEY_SECOND
                              && st_q.key_st == NPE_K_ARMED))
    else $error("window opened without key sequence");
  AST_WIN_CLOSES_ON_TICK: assert property (@(posedge clk) disable iff (srst)
    $fell(win_open) |-> $past(mc_tick))
    else $error("window closed without machine cycle");
  AST_ABANDON: assert property (@(posedge clk) disable iff (srst)
    (st_q.key_st == NPE_K_ARMED && req.wr && !key_wr) |=> st_q.key_st == NPE_K_IDLE)
    else $error("foreign write kept sequence armed");
  COV_WINDOW: cover property (@(posedge clk) disable iff (srst) $rose(win_open));
endmodule

// ---- npe_ctrl.sv ----
// nonvolatile data memory control: registers, erase and write sequencing
`timescale 1ns/1ps
`include "npe_cfg.svh"
module npe_ctrl #(
  parameter logic [`NPE_CNT_W-1:0] ERASE_MC = `NPE_ERASE_MC,
  parameter logic [`NPE_CNT_W-1:0] WRITE_MC = `NPE_WRITE_MC
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire npe_pkg::npe_sfr_req_t sfr_req,
  output logic [7:0]                 sfr_rdata,
  input  wire logic                  mc_tick,
  output logic                       pc_hold,
  output logic                       pc_advance,
  input  wire logic                  movc_rd,
  input  wire logic [7:0]            movc_addr,
  output logic [7:0]                 movc_data
);
  import npe_pkg::*;

  localparam npe_state_t RST = '{
    op:        NPE_IDLE,
    cnt:       '0,
    addr_low:  `NPE_ZERO8,
    wdata:     `NPE_ZERO8,
    rdata:     `NPE_ZERO8,
    movc_data: `NPE_ZERO8,
    done:      1'b0,
    mem:       {`NPE_MEM_BYTES{`NPE_ERASED}}
  };

  npe_state_t st_q;
  npe_state_t st_d;
  logic       win_open;
  logic       ctrl_wr;
  logic [1:0] page_sel;

  // --------------------------------------------------------------
  // unlock window
  // --------------------------------------------------------------
  npe_unlock u_unlock (
    .clk      (clk),
    .srst     (srst),
    .req      (sfr_req),
    .mc_tick  (mc_tick),
    .win_open (win_open)
  );

  assign ctrl_wr  = sfr_req.wr && (sfr_req.addr == `NPE_ADDR_CTRL);
  assign page_sel = st_q.addr_low[`NPE_PAGE_MSB:`NPE_PAGE_LSB];

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    if (st_q.op == NPE_IDLE) begin
      // busy period freezes the setup registers so the running op stays consistent
      if (sfr_req.wr && sfr_req.addr == `NPE_ADDR_LOW) begin
        st_d.addr_low = sfr_req.wdata;
      end
      if (sfr_req.wr && sfr_req.addr == `NPE_ADDR_DATA) begin
        st_d.wdata = sfr_req.wdata;
      end
      // a closed window drops the control write; like any other write it still disarms a pending key sequence
      if (ctrl_wr && win_open) begin
        // erase wins if both bits are set in one write
        if (sfr_req.wdata[`NPE_BIT_ERASE]) begin
          st_d.op  = NPE_ERASE;
          st_d.cnt = ERASE_MC;
        end else if (sfr_req.wdata[`NPE_BIT_WRITE]) begin
          st_d.op  = NPE_WRITE;
          st_d.cnt = WRITE_MC;
        end
      end
    end else if (mc_tick) begin
      // the last machine cycle commits the array update and frees the core
      if (st_q.cnt <= {{(`NPE_CNT_W-1){1'b0}}, 1'b1}) begin
        st_d.op   = NPE_IDLE;
        st_d.done = 1'b1;
        st_d.cnt  = '0;
        if (st_q.op == NPE_ERASE) begin
          for (int i = 0; i < `NPE_PAGE_BYTES; i++) begin
            st_d.mem[{page_sel, i[5:0]}] = `NPE_ERASED;
          end
        end else begin
          st_d.mem[st_q.addr_low] = st_q.wdata;
        end
      end else begin
        st_d.cnt = st_q.cnt - {{(`NPE_CNT_W-1){1'b0}}, 1'b1};
      end
    end
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        `NPE_ADDR_LOW:  st_d.rdata = st_q.addr_low;
        `NPE_ADDR_CTRL: st_d.rdata = {st_q.op == NPE_ERASE, st_q.op == NPE_WRITE, 6'h00};
        // data register reads back what was loaded, not the array
        `NPE_ADDR_DATA: st_d.rdata = st_q.wdata;
        default:        st_d.rdata = `NPE_ZERO8;
      endcase
    end
    // code read sees the array as it stood before this edge
    if (movc_rd) begin
      st_d.movc_data = st_q.mem[movc_addr];
    end
  end

  // one state register keeps reset and update of every field in step
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata  = st_q.rdata;
  assign movc_data  = st_q.movc_data;
  assign pc_hold    = (st_q.op != NPE_IDLE);
  // advance is registered so it lines up with the falling hold
  assign pc_advance = st_q.done;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  AST_ERASE_START: assert property (@(posedge clk) disable iff (srst)
    (!pc_hold && ctrl_wr && win_open && sfr_req.wdata[`NPE_BIT_ERASE])
      |=> (st_q.op == NPE_ERASE && pc_hold))
    else $error("erase did not start");
  AST_WRITE_START: assert property (@(posedge clk) disable iff (srst)
    (!pc_hold && ctrl_wr && win_open && !sfr_req.wdata[`NPE_BIT_ERASE]
      && sfr_req.wdata[`NPE_BIT_WRITE]) |=> (st_q.op == NPE_WRITE && pc_hold))
    else $error("byte write did not start");
  AST_CLOSED_IGNORED: assert property (@(posedge clk) disable iff (srst)
    (!pc_hold && ctrl_wr && !win_open) |=> !pc_hold)
    else $error("protected write accepted outside window");
  AST_ZERO_NO_START: assert property (@(posedge clk) disable iff (srst)
    (!pc_hold && ctrl_wr && !sfr_req.wdata[`NPE_BIT_ERASE]
      && !sfr_req.wdata[`NPE_BIT_WRITE]) |=> !pc_hold)
    else $error("zero bits started an operation");
  AST_ADVANCE_AT_END: assert property (@(posedge clk) disable iff (srst)
    $fell(pc_hold) |-> pc_advance)
    else $error("no advance at end of operation");
  AST_ADVANCE_ONLY_END: assert property (@(posedge clk) disable iff (srst)
    pc_advance |-> ($past(pc_hold) && !pc_hold && $past(mc_tick)))
    else $error("advance without finished operation");
  AST_PAGE_ERASED: assert property (@(posedge clk) disable iff (srst)
    (pc_advance && $past(st_q.op) == NPE_ERASE)
      |-> (st_q.mem[{page_sel, 6'h00}] == `NPE_ERASED
           && st_q.mem[{page_sel, 6'h3F}] == `NPE_ERASED))
    else $error("selected page not erased");
  AST_BYTE_STORED: assert property (@(posedge clk) disable iff (srst)
    (pc_advance && $past(st_q.op) == NPE_WRITE) |-> st_q.mem[st_q.addr_low] == st_q.wdata)
    else $error("byte not programmed");
  AST_MOVC_READ: assert property (@(posedge clk) disable iff (srst)
    movc_rd |=> movc_data == $past(st_q.mem[movc_addr]))
    else $error("code read returned wrong byte");
  AST_ADDR_READ: assert property (@(posedge clk) disable iff (srst)
    (sfr_req.rd && sfr_req.addr == `NPE_ADDR_LOW) |=> sfr_rdata == $past(st_q.addr_low))
    else $error("address register read wrong");

  // --------------------------------------------------------------
  // checks: busy period, register reads and operation length
  // --------------------------------------------------------------
  AST_SETUP_FROZEN: assert property (@(posedge clk) disable iff (srst)
    pc_hold |=> ($stable(st_q.addr_low) && $stable(st_q.wdata)))
    else $error("setup register changed during operation");
  AST_HOLD_STAYS: assert property (@(posedge clk) disable iff (srst)
    (pc_hold && !mc_tick) |=> pc_hold)
    else $error("hold dropped without machine cycle");
  AST_ADVANCE_PULSE: assert property (@(posedge clk) disable iff (srst)
    pc_advance |=> !pc_advance)
    else $error("advance longer than one cycle");
  AST_ERASE_LEN: assert property (@(posedge clk) disable iff (srst)
    (!pc_hold && ctrl_wr && win_open && sfr_req.wdata[`NPE_BIT_ERASE])
      |=> st_q.cnt == ERASE_MC)
    else $error("erase length not loaded");
  AST_WRITE_LEN: assert property (@(posedge clk) disable iff (srst)
    (!pc_hold && ctrl_wr && win_open && !sfr_req.wdata[`NPE_BIT_ERASE]
      && sfr_req.wdata[`NPE_BIT_WRITE]) |=> st_q.cnt == WRITE_MC)
    else $error("write length not loaded");
  AST_CTRL_READ: assert property (@(posedge clk) disable iff (srst)
    (sfr_req.rd && sfr_req.addr == `NPE_ADDR_CTRL)
      |=> (sfr_rdata[5:0] == 6'h00
           && ((sfr_rdata[7:6] != 2'h0) == $past(pc_hold))))
    else $error("control read does not match busy state");
  AST_DATA_READ: assert property (@(posedge clk) disable iff (srst)
    (sfr_req.rd && sfr_req.addr == `NPE_ADDR_DATA) |=> sfr_rdata == $past(st_q.wdata))
    else $error("write data register read wrong");
  AST_KEY_READ: assert property (@(posedge clk) disable iff (srst)
    (sfr_req.rd && sfr_req.addr == `NPE_ADDR_KEY) |=> sfr_rdata == `NPE_ZERO8)
    else $error("key register read not zero");
  AST_ADDR_LOADED: assert property (@(posedge clk) disable iff (srst)
    (!pc_hold && sfr_req.wr && sfr_req.addr == `NPE_ADDR_LOW)
      |=> st_q.addr_low == $past(sfr_req.wdata))
    else $error("address register not loaded");
  AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (srst)
    !sfr_req.rd |=> $stable(sfr_rdata))
    else $error("register read data changed without read");
  AST_MOVC_HOLD: assert property (@(posedge clk) disable iff (srst)
    !movc_rd |=> $stable(movc_data))
    else $error("code read data changed without read");
  COV_ERASE_DONE: cover property (@(posedge clk) disable iff (srst)
    pc_advance && $past(st_q.op) == NPE_ERASE);
  COV_WRITE_DONE: cover property (@(posedge clk) disable iff (srst)
    pc_advance && $past(st_q.op) == NPE_WRITE);
  COV_CLOSED_TRY: cover property (@(posedge clk) disable iff (srst)
    ctrl_wr && !win_open && sfr_req.wdata[`NPE_BIT_ERASE]);
  COV_BOTH_BITS: cover property (@(posedge clk) disable iff (srst)
    !pc_hold && ctrl_wr && win_open && sfr_req.wdata[`NPE_BIT_ERASE]
      && sfr_req.wdata[`NPE_BIT_WRITE]);
endmodule

// ---- npe_tb.sv ----
// self-checking testbench of the nonvolatile page erase / byte write control
`timescale 1ns/1ps
`include "npe_cfg.svh"
module testbench;
  import npe_pkg::*;
  // ----------------------------------------
  // stimulus and design
  // ----------------------------------------
  localparam logic [15:0] ERASE_N = 16'h0003;
  localparam logic [15:0] WRITE_N = 16'h0002;
  logic         clk;
  logic         srst;
  npe_sfr_req_t sreq;
  logic [7:0]   sfr_rdata;
  logic         mc_tick;
  logic         pc_hold;
  logic         pc_advance;
  logic         movc_rd;
  logic [7:0]   movc_addr;
  logic [7:0]   movc_data;
  logic [7:0]   mem_m [256];
  int           num_errors = 0;
  int           n_tests    = 0;
  logic [7:0]   rst_addr [6];

  npe_ctrl #(.ERASE_MC(ERASE_N), .WRITE_MC(WRITE_N)) dut_u (
    .clk(clk), .srst(srst), .sfr_req(sreq), .sfr_rdata(sfr_rdata), .mc_tick(mc_tick),
    .pc_hold(pc_hold), .pc_advance(pc_advance), .movc_rd(movc_rd),
    .movc_addr(movc_addr), .movc_data(movc_data));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // tasks and expectation functions
  // ----------------------------------------
  function automatic logic [7:0] busy_of(input logic [7:0] cv);
    return cv[7] ? 8'h80 : (cv[6] ? 8'h40 : 8'h00);  // erase outranks write
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  // each transfer ends with an idle edge so strobes never toggle twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sreq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc();
    sreq.wr = 1'b0;
    cyc();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    sreq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cyc();
    sreq.rd = 1'b0;
    v = sfr_rdata;
    cyc();
  endtask
  task automatic mrd(input logic [7:0] a, output logic [7:0] v);
    movc_rd = 1'b1;
    movc_addr = a;
    cyc();
    movc_rd = 1'b0;
    v = movc_data;
    cyc();
  endtask
  // strobe stays high across back-to-back machine cycles
  task automatic tick(input int n);
    if (n > 0) begin
      mc_tick = 1'b1;
      repeat (n) cyc();
      mc_tick = 1'b0;
    end
  endtask
  task automatic unlock();
    wr(`NPE_ADDR_KEY, `NPE_KEY_FIRST);
    wr(`NPE_ADDR_KEY, `NPE_KEY_SECOND);
  endtask
  task automatic stat(input logic [7:0] exp);
    chk("hold_advance", {6'h00, pc_hold, pc_advance}, exp);
  endtask
  // window assumed open; cv is the control value, n the machine-cycle length
  task automatic run_op(input logic [7:0] cv, input int n);
    logic [7:0] v;
    wr(`NPE_ADDR_CTRL, cv);
    stat(8'h02);
    rd(`NPE_ADDR_CTRL, v);
    chk("ctrl_busy", v, busy_of(cv));
    wr(`NPE_ADDR_DATA, ~cv);  // ignored while busy
    tick(n - 1);
    stat(8'h02);
    cyc();
    tick(1);
    stat(8'h01);
    cyc();
    stat(8'h00);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] v;
    srst = 1'b1;
    sreq = '0;
    mc_tick = 1'b0;
    movc_rd = 1'b0;
    movc_addr = 8'h00;
    void'($urandom(32'h1c8487dc));
    foreach (mem_m[i]) mem_m[i] = `NPE_ERASED;
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    cyc();
    rst_addr = '{8'hC6, 8'hC7, 8'hCE, 8'hCF, 8'h00, 8'hC5};
    foreach (rst_addr[i]) begin
      rd(rst_addr[i], v);
      chk("reset_read", v, 8'h00);
    end
    mrd(8'($urandom), v);
    chk("reset_array", v, `NPE_ERASED);
    $display("test reset done");
    // locked, expired window and broken key must all leave the core running
    wr(`NPE_ADDR_CTRL, 8'h40);
    stat(8'h00);
    unlock();
    tick(3);
    wr(`NPE_ADDR_CTRL, 8'h80);
    stat(8'h00);
    wr(`NPE_ADDR_KEY, `NPE_KEY_FIRST);
    wr(`NPE_ADDR_DATA, 8'h3C);
    wr(`NPE_ADDR_KEY, `NPE_KEY_SECOND);
    wr(`NPE_ADDR_CTRL, 8'h40);
    stat(8'h00);
    $display("test protection done");
    repeat (6) begin
      a = 8'($urandom);
      d = 8'($urandom);
      wr(`NPE_ADDR_LOW, a);
      wr(`NPE_ADDR_DATA, d);
      rd(`NPE_ADDR_DATA, v);
      chk("write_data_reg", v, d);
      rd(`NPE_ADDR_LOW, v);
      chk("addr_reg", v, a);
      unlock();
      tick(2);  // last machine cycle of the window still counts
      run_op(8'h40, int'(WRITE_N));
      mem_m[a] = d;
      mrd(a, v);
      chk("byte_written", v, d);
    end
    $display("test byte write done");
    for (int p = 0; p < `NPE_PAGES; p += 3) begin
      wr(`NPE_ADDR_LOW, {2'(p), 6'($urandom)});
      unlock();
      run_op(8'hC0, int'(ERASE_N));
      for (int j = 0; j < `NPE_PAGE_BYTES; j++) mem_m[p * `NPE_PAGE_BYTES + j] = `NPE_ERASED;
      for (int k = 0; k < `NPE_MEM_BYTES; k++) begin
        mrd(8'(k), v);
        chk("array_after_erase", v, mem_m[k]);
      end
    end
    $display("test page erase done");
    give_verdict();
  end

  initial begin
    #200000;
    num_errors++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule
